// ### src/osr_rx_ctrl.sv
// Receive-bus lane mapping and strap/register control of an octal serdes, channels G and H.
// Assumes decoder, encoder and serial words arrive on core_clk_i; straps and the
// receive clock arrive asynchronously and are synchronised here.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module osr_rx_ctrl (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Asynchronous pins
   input wire logic rx_clock_i,
   input wire logic chip_reset_i,
   input wire logic device_enable_i,
   input wire logic coding_select_i,
   input wire logic error_fill_enable_i,
   input wire logic serial_loopback_i,
   input wire logic [1:0] interface_mode_i,
   input wire logic transfer_clock_select_i,
   input wire logic busy_pass_enable_i,
   input wire logic gig_ethernet_select_i,
   input wire logic pattern_test_enable_i,
   input wire logic [4:0] phy_address_inputs_i,
   // Decoded receive words, channels G and H
   input wire logic [9:0] rx_raw_g_i,
   input wire logic [7:0] rx_data_g_i,
   input wire logic rx_k_g_i,
   input wire logic rx_err_g_i,
   input wire logic [9:0] rx_raw_h_i,
   input wire logic [7:0] rx_data_h_i,
   input wire logic rx_k_h_i,
   input wire logic rx_err_h_i,
   // Serial side words
   input wire logic [9:0] tx_enc_g_i,
   input wire logic [9:0] tx_enc_h_i,
   input wire logic [9:0] rx_serial_g_i,
   input wire logic [9:0] rx_serial_h_i,
   output logic [9:0] dec_in_g_o,
   output logic [9:0] dec_in_h_o,
   output logic [9:0] tx_serial_g_o,
   output logic [9:0] tx_serial_h_o,
   output logic tx_serial_oe_o,
   // Transmit character stream, channel H
   input wire logic [7:0] tx_char_i,
   input wire logic tx_k_i,
   input wire logic tx_char_valid_i,
   output logic [7:0] tx_char_o,
   output logic tx_k_o,
   output logic tx_char_valid_o,
   // Receive bus
   output logic [9:0] rx_bus_pair_gh_o,
   output logic rx_bus_oe_o,
   // Test port
   input wire logic jtag_active_i,
   input wire logic jtag_tdo_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // Status levels
   output logic [4:0] phy_address_strap_o,
   output logic recenter_o,
   output logic coding_enable_o,
   output logic transfer_clock_select_o,
   output logic idle_deletable_o
);
   import osr_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [OSR_NPIN-1:0] sync1;
      logic [OSR_NPIN-1:0] sync2;
      logic rclk_q;
      logic crst_q;
      logic [9:0] bus;
      logic cfg_code;
      logic cfg_fill;
      logic cfg_tclk;
      logic ge_bit;
      logic sticky_err;
      logic [15:0] prbs_cnt;
      logic [6:0] prbs_st;
      logic [4:0] phy_addr;
      logic prev_k_rx;
      logic idle_del;
      osr_corr_st_t corr_st;
      logic [7:0] tx_char;
      logic tx_k;
      logic tx_vld;
      logic [9:0] ser_g;
      logic [9:0] ser_h;
      logic [9:0] dec_g;
      logic [9:0] dec_h;
      logic tdo;
      logic [31:0] prdata;
      logic slverr;
   } osr_state_t;

   osr_state_t s_r;
   osr_state_t s_nxt;
   logic [1:0] rst_pipe_r;
   logic rst_n;

   // Release of the asynchronous reset is retimed so all flops leave reset together
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_pipe_r <= 2'h0;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_r[1];

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Ten steps of x^7 + x^6 + 1 per word; returns {next state, word}
   function automatic logic [16:0] prbs_step(input logic [6:0] st_in);
      logic [6:0] st;
      logic [9:0] w;
      logic b;
      st = st_in;
      w = 10'h000;
      for (int i = 0; i < 10; i++) begin
         b = st[6] ^ st[5];
         st = {st[5:0], b};
         w = {w[8:0], b};
      end
      return {st, w};
   endfunction

   logic [OSR_NPIN-1:0] pins;
   logic rise, fall, coded, fill_on, loop_on, en, ge, busy, prbs, crst;
   logic [1:0] mode;
   logic [9:0] word_g, word_h, lane_rise, lane_fall;
   logic [16:0] pr;
   logic fill_rise, fill_fall, k285_tx, dat_tx, swap;
   logic setup, access, hit;
   logic [9:0] idx;
   logic [31:0] rd_mux;

   assign pins = {phy_address_inputs_i, pattern_test_enable_i, gig_ethernet_select_i,
                  busy_pass_enable_i, transfer_clock_select_i, interface_mode_i,
                  serial_loopback_i, error_fill_enable_i, coding_select_i,
                  device_enable_i, chip_reset_i, rx_clock_i};

   assign rise = s_r.sync2[OSR_PIN_RCLK] & ~s_r.rclk_q;
   assign fall = ~s_r.sync2[OSR_PIN_RCLK] & s_r.rclk_q;
   assign crst = s_r.sync2[OSR_PIN_CRST];
   assign en = s_r.sync2[OSR_PIN_EN];
   assign coded = s_r.sync2[OSR_PIN_CODE] | s_r.cfg_code;
   assign fill_on = (s_r.sync2[OSR_PIN_FILL] | s_r.cfg_fill) & coded;
   assign loop_on = s_r.sync2[OSR_PIN_LOOP];
   assign mode = s_r.sync2[OSR_PIN_MODE +: 2];
   assign ge = s_r.sync2[OSR_PIN_GE] | s_r.ge_bit;
   assign busy = s_r.sync2[OSR_PIN_BUSY];
   assign prbs = s_r.sync2[OSR_PIN_PRBS];
   assign pr = prbs_step(s_r.prbs_st);

   // Coded words carry the K-flag in bit 8 so in nibble mode lanes 3 and 8 pick it up on the rising phase
   assign word_g = coded ? {1'b0, rx_k_g_i, rx_data_g_i} : rx_raw_g_i;
   assign word_h = coded ? {1'b0, rx_k_h_i, rx_data_h_i} : rx_raw_h_i;

   // ----------------------------------------------------------------
   // Lane mapping per phase
   // ----------------------------------------------------------------
   always_comb begin
      fill_rise = 1'b0;
      fill_fall = 1'b0;
      lane_rise = 10'h000;
      lane_fall = 10'h000;
      case (mode)
         OSR_MODE_MUX: begin
            fill_rise = fill_on & rx_err_h_i;
            fill_fall = fill_on & rx_err_g_i;
            lane_rise = word_h;
            lane_fall = word_g;
         end
         OSR_MODE_NIB: begin
            fill_rise = fill_on & (rx_err_g_i | rx_err_h_i);
            fill_fall = fill_rise;
            lane_rise = {word_h[9:5], word_g[9:5]};
            lane_fall = {word_h[4:0], word_g[4:0]};
         end
         default: begin
            // Reserved codes keep the bus quiet rather than guess a layout
            lane_rise = 10'h000;
            lane_fall = 10'h000;
         end
      endcase
      if (fill_rise) begin
         lane_rise = 10'h3ff;
      end
      if (fill_fall) begin
         lane_fall = 10'h3ff;
      end
   end

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign idx = paddr_i[11:2];
   assign hit = (idx == OSR_CFG_IDX) | (idx == OSR_STAT_IDX) | (idx == OSR_GE_IDX);

   always_comb begin
      rd_mux = OSR_REG_RESET;
      if (idx == OSR_CFG_IDX) begin
         rd_mux[OSR_CODE_BIT] = s_r.cfg_code;
         rd_mux[OSR_FILL_BIT] = s_r.cfg_fill;
         rd_mux[OSR_TCLK_BIT] = s_r.cfg_tclk;
      end else if (idx == OSR_GE_IDX) begin
         rd_mux[OSR_GE_BIT] = s_r.ge_bit;
      end else if (idx == OSR_STAT_IDX) begin
         rd_mux[OSR_ST_ERR_BIT] = s_r.sticky_err;
         rd_mux[OSR_ST_CODE_BIT] = coded;
         rd_mux[OSR_ST_LOOP_BIT] = loop_on;
         rd_mux[OSR_ST_GE_BIT] = ge;
         rd_mux[OSR_ST_ADDR_POS +: 5] = s_r.phy_addr;
         rd_mux[OSR_ST_CNT_POS +: 16] = s_r.prbs_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      k285_tx = tx_k_i & (tx_char_i == OSR_K28_5);
      dat_tx = ~tx_k_i;
      swap = 1'b0;
      s_nxt.sync1 = pins;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.rclk_q = s_r.sync2[OSR_PIN_RCLK];
      s_nxt.crst_q = crst;
      s_nxt.tdo = jtag_tdo_i;

      if (rise) begin
         s_nxt.bus = lane_rise;
      end else if (fall) begin
         s_nxt.bus = lane_fall;
      end

      if (crst & ~s_r.crst_q) begin
         s_nxt.phy_addr = s_r.sync2[OSR_PIN_ADDR +: 5];
      end

      // Sticky decode error; a new error beats a clear in the same cycle
      if (access & pwrite_i & (idx == OSR_STAT_IDX) & pwdata_i[OSR_ST_ERR_BIT]) begin
         s_nxt.sticky_err = 1'b0;
      end
      if ((rise | fall) & coded & (rx_err_g_i | rx_err_h_i)) begin
         s_nxt.sticky_err = 1'b1;
      end

      if (rise) begin
         // Loopback ignores serial input and drives the decoder from the encoder
         s_nxt.dec_g = loop_on ? tx_enc_g_i : rx_serial_g_i;
         s_nxt.dec_h = loop_on ? tx_enc_h_i : rx_serial_h_i;
         s_nxt.ser_g = prbs ? pr[9:0] : tx_enc_g_i;
         s_nxt.ser_h = prbs ? pr[9:0] : tx_enc_h_i;
         if (prbs) begin
            s_nxt.prbs_st = pr[16:10];
            if (((rx_serial_g_i != pr[9:0]) | (rx_serial_h_i != pr[9:0]))
                & (s_r.prbs_cnt != OSR_CNT_MAX)) begin
               s_nxt.prbs_cnt = s_r.prbs_cnt + 16'h0001;
            end
         end
         // Idle pair classification on channel H
         s_nxt.prev_k_rx = coded & rx_k_h_i & ~rx_err_h_i & (rx_data_h_i == OSR_K28_5);
         s_nxt.idle_del = coded & s_r.prev_k_rx & ~rx_k_h_i & ~rx_err_h_i
                          & ((ge & ~(busy & (rx_data_h_i == OSR_D10_1)))
                             | (~busy & (rx_data_h_i == OSR_D10_1)));
      end

      // Transmit idle correction, channel H
      s_nxt.tx_vld = tx_char_valid_i;
      s_nxt.tx_k = tx_k_i;
      s_nxt.tx_char = tx_char_i;
      if (tx_char_valid_i) begin
         case (s_r.corr_st)
            OSR_CORR_ON: s_nxt.corr_st = k285_tx ? OSR_CORR_K1 : OSR_CORR_ON;
            OSR_CORR_K1: begin
               s_nxt.corr_st = k285_tx ? OSR_CORR_OFF : OSR_CORR_ON;
               swap = ge & dat_tx & (tx_char_i == OSR_D16_2);
            end
            OSR_CORR_OFF: s_nxt.corr_st = dat_tx ? OSR_CORR_D1 : OSR_CORR_OFF;
            OSR_CORR_D1: s_nxt.corr_st = dat_tx ? OSR_CORR_ON : OSR_CORR_OFF;
            default: s_nxt.corr_st = OSR_CORR_ON;
         endcase
         if (swap) begin
            s_nxt.tx_char = OSR_D5_6;
         end
      end

      // Register access: data captured in setup, write takes effect in access
      if (setup) begin
         s_nxt.prdata = rd_mux;
         s_nxt.slverr = ~hit;
      end
      if (access & pwrite_i) begin
         if (idx == OSR_CFG_IDX) begin
            s_nxt.cfg_code = pwdata_i[OSR_CODE_BIT];
            s_nxt.cfg_fill = pwdata_i[OSR_FILL_BIT];
            s_nxt.cfg_tclk = pwdata_i[OSR_TCLK_BIT];
         end else if (idx == OSR_GE_IDX) begin
            s_nxt.ge_bit = pwdata_i[OSR_GE_BIT];
         end
      end

      // Chip reset holds status cleared and the pattern checker recentered
      if (crst) begin
         s_nxt.prbs_cnt = 16'h0000;
         s_nxt.sticky_err = 1'b0;
         s_nxt.prbs_st = OSR_PRBS_SEED;
         s_nxt.prev_k_rx = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.corr_st <= OSR_CORR_ON;
         s_r.prbs_st <= OSR_PRBS_SEED;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o = s_r.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = access & s_r.slverr;
   assign rx_bus_pair_gh_o = s_r.bus;
   assign rx_bus_oe_o = en;
   assign tx_serial_oe_o = en & ~loop_on;
   assign tdo_o = s_r.tdo;
   assign tdo_oe_o = en & jtag_active_i;
   assign dec_in_g_o = s_r.dec_g;
   assign dec_in_h_o = s_r.dec_h;
   assign tx_serial_g_o = s_r.ser_g;
   assign tx_serial_h_o = s_r.ser_h;
   assign tx_char_o = s_r.tx_char;
   assign tx_k_o = s_r.tx_k;
   assign tx_char_valid_o = s_r.tx_vld;
   assign phy_address_strap_o = s_r.phy_addr;
   assign recenter_o = crst;
   assign coding_enable_o = coded;
   assign transfer_clock_select_o = s_r.sync2[OSR_PIN_TCLK] | s_r.cfg_tclk;
   assign idle_deletable_o = s_r.idle_del;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);

   chk_mux_rise_h: assert property (rise && mode == OSR_MODE_MUX && !fill_rise
      |=> rx_bus_pair_gh_o == $past(word_h)) else $error("mux rising phase not channel H");
   chk_nib_fall_low: assert property (fall && mode == OSR_MODE_NIB && !fill_fall
      |=> rx_bus_pair_gh_o == {$past(word_h[4:0]), $past(word_g[4:0])})
      else $error("nibble falling phase wrong");
   chk_lane3_kflag: assert property (rise && mode == OSR_MODE_NIB && coded && !fill_rise
      |=> rx_bus_pair_gh_o[3] == $past(rx_k_g_i)) else $error("lane 3 K-flag wrong");
   chk_lane8_mux: assert property (rise && mode == OSR_MODE_MUX && !fill_rise
      |=> rx_bus_pair_gh_o[8] == $past(coded ? rx_k_h_i : rx_raw_h_i[8]))
      else $error("lane 8 wrong in mux mode");
   chk_lane9_raw: assert property (rise && mode == OSR_MODE_MUX && !coded
      |=> rx_bus_pair_gh_o[9] == $past(rx_raw_h_i[9])) else $error("lane 9 not bit ten");
   chk_lane9_nib: assert property (fall && mode == OSR_MODE_NIB && !coded
      |=> rx_bus_pair_gh_o[9] == $past(rx_raw_h_i[4])) else $error("lane 9 not bit five");
   chk_lane8_nib: assert property (fall && mode == OSR_MODE_NIB && !fill_fall
      |=> rx_bus_pair_gh_o[8] == $past(word_h[3])) else $error("lane 8 not bit four");
   chk_error_fill: assert property (rise && fill_on && mode == OSR_MODE_MUX && rx_err_h_i
      |=> rx_bus_pair_gh_o == 10'h3ff) else $error("error fill missing");
   chk_addr_latch: assert property ($rose(crst) |=>
      phy_address_strap_o == $past(s_r.sync2[OSR_PIN_ADDR +: 5]))
      else $error("address strap not latched");
   chk_tdo_hiz: assert property (!jtag_active_i |-> !tdo_oe_o)
      else $error("test output driven while idle");
   chk_enable_off: assert property (!en |-> !rx_bus_oe_o && !tx_serial_oe_o && !tdo_oe_o)
      else $error("output enabled while device disabled");
   chk_loop_hiz: assert property (loop_on |-> !tx_serial_oe_o)
      else $error("serial output driven in loopback");
   chk_reset_clear: assert property (crst ##1 crst |-> s_r.prbs_cnt == 16'h0000)
      else $error("status not cleared under chip reset");
   chk_idle_off: assert property (s_r.corr_st == OSR_CORR_K1 && tx_char_valid_i && k285_tx
      |=> s_r.corr_st == OSR_CORR_OFF) else $error("correction not disabled");
   chk_d16_swap: assert property (swap |=> tx_char_o == OSR_D5_6 && tx_char_valid_o)
      else $error("idle disparity swap missing");
   chk_code_or: assert property (s_r.cfg_code |-> coding_enable_o)
      else $error("register coding bit ignored");

   cov_mux_rise: cover property (rise && mode == OSR_MODE_MUX && coded);
   cov_nib_fill: cover property (fall && mode == OSR_MODE_NIB && fill_fall);
   cov_idle_del: cover property (idle_deletable_o);
   cov_tx_swap: cover property (swap);

endmodule

`default_nettype wire

// ### src/osr_pkg.sv
// Constants shared by the receive-bus and control block of the octal serdes.
// Assumes the block runs on one core clock and sees all straps through synchronisers.
package osr_pkg;

   // ----------------------------------------------------------------
   // Strap and pin vector layout
   // ----------------------------------------------------------------
   localparam int OSR_PIN_RCLK = 0;
   localparam int OSR_PIN_CRST = 1;
   localparam int OSR_PIN_EN = 2;
   localparam int OSR_PIN_CODE = 3;
   localparam int OSR_PIN_FILL = 4;
   localparam int OSR_PIN_LOOP = 5;
   localparam int OSR_PIN_MODE = 6;
   localparam int OSR_PIN_TCLK = 8;
   localparam int OSR_PIN_BUSY = 9;
   localparam int OSR_PIN_GE = 10;
   localparam int OSR_PIN_PRBS = 11;
   localparam int OSR_PIN_ADDR = 12;
   localparam int OSR_NPIN = 17;

   // ----------------------------------------------------------------
   // Register map (index, byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] OSR_CFG_IDX = 10'h011;
   localparam logic [9:0] OSR_STAT_IDX = 10'h012;
   localparam logic [9:0] OSR_GE_IDX = 10'h018;
   localparam int OSR_CODE_BIT = 7;
   localparam int OSR_FILL_BIT = 14;
   localparam int OSR_TCLK_BIT = 15;
   localparam int OSR_GE_BIT = 15;
   localparam int OSR_ST_ERR_BIT = 0;
   localparam int OSR_ST_CODE_BIT = 1;
   localparam int OSR_ST_LOOP_BIT = 2;
   localparam int OSR_ST_GE_BIT = 3;
   localparam int OSR_ST_ADDR_POS = 5;
   localparam int OSR_ST_CNT_POS = 16;
   localparam logic [31:0] OSR_REG_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Modes and characters
   // ----------------------------------------------------------------
   localparam logic [1:0] OSR_MODE_MUX = 2'h0;
   localparam logic [1:0] OSR_MODE_NIB = 2'h2;
   localparam logic [7:0] OSR_K28_5 = 8'hbc;
   localparam logic [7:0] OSR_D10_1 = 8'h2a;
   localparam logic [7:0] OSR_D16_2 = 8'h50;
   localparam logic [7:0] OSR_D5_6 = 8'hc5;
   localparam logic [6:0] OSR_PRBS_SEED = 7'h7f;
   localparam logic [15:0] OSR_CNT_MAX = 16'hffff;

   typedef enum logic [3:0] {
      OSR_CORR_ON = 4'h1,
      OSR_CORR_K1 = 4'h2,
      OSR_CORR_OFF = 4'h4,
      OSR_CORR_D1 = 4'h8
   } osr_corr_st_t;

endpackage

// ### bench/osr_proto_model.sv
// Protocol device side model: sources the receive clock of the parallel bus.
// Assumes the bench raises run_i only while it wants receive traffic.
`timescale 1ns/100ps
`default_nettype none

module osr_proto_model (
   // Control
   input wire logic run_i,
   // Receive clock toward the block
   output logic rx_clock_o
);
   // Odd offset keeps the edges clear of the core clock edges
   initial begin
      rx_clock_o = 1'h0;
      #1.3;
      forever begin
         #40;
         if (run_i) begin
            rx_clock_o = ~rx_clock_o;
         end
      end
   end
endmodule

`default_nettype wire

// ### bench/octal_serdes_rx_bus_and_control_tb.sv
// Self-checking bench for the receive-bus and control block.
// Assumes a 250 MHz core clock and the receive clock from the protocol model.
`timescale 1ns/100ps
`default_nettype none

module octal_serdes_rx_bus_and_control_tb;
   import osr_pkg::*;

   logic clk = 1'h0;
   logic rst_n, psel, pen, pwr, crst, en, code, fill, loopback, tcs, ge, jact, busy, pat;
   logic k_g, k_h, err_g, err_h, txk, txv, run, e;
   logic [1:0] mode;
   logic [4:0] addr;
   logic [7:0] dat_g, dat_h, txc;
   logic [9:0] raw_g, raw_h, enc;
   logic [11:0] paddr;
   logic [31:0] pwdata, q;
   wire logic rclk, prdy, perr, bus_oe, ser_oe, tdo_oe, rcen, code_o, tcs_o, txv_o, idl;
   wire logic [4:0] strap;
   wire logic [7:0] txc_o;
   wire logic [9:0] bus, dec_g;
   wire logic [31:0] prdata;
   int fails = 0;
   int n_checks = 0;
   int m, c;

   always #2 clk = ~clk;

   osr_proto_model peer (.run_i(run), .rx_clock_o(rclk));
   osr_rx_ctrl uut (
      .core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
      .rx_clock_i(rclk), .chip_reset_i(crst), .device_enable_i(en), .coding_select_i(code),
      .error_fill_enable_i(fill), .serial_loopback_i(loopback), .interface_mode_i(mode),
      .transfer_clock_select_i(tcs), .busy_pass_enable_i(busy), .gig_ethernet_select_i(ge),
      .pattern_test_enable_i(pat), .phy_address_inputs_i(addr),
      .rx_raw_g_i(raw_g), .rx_data_g_i(dat_g), .rx_k_g_i(k_g), .rx_err_g_i(err_g),
      .rx_raw_h_i(raw_h), .rx_data_h_i(dat_h), .rx_k_h_i(k_h), .rx_err_h_i(err_h),
      .tx_enc_g_i(enc), .tx_enc_h_i(enc), .rx_serial_g_i(10'h0), .rx_serial_h_i(10'h0),
      .dec_in_g_o(dec_g), .dec_in_h_o(), .tx_serial_g_o(), .tx_serial_h_o(),
      .tx_serial_oe_o(ser_oe), .tx_char_i(txc), .tx_k_i(txk), .tx_char_valid_i(txv),
      .tx_char_o(txc_o), .tx_k_o(), .tx_char_valid_o(txv_o), .rx_bus_pair_gh_o(bus),
      .rx_bus_oe_o(bus_oe), .jtag_active_i(jact), .jtag_tdo_i(1'h0), .tdo_o(),
      .tdo_oe_o(tdo_oe), .phy_address_strap_o(strap), .recenter_o(rcen),
      .coding_enable_o(code_o), .transfer_clock_select_o(tcs_o), .idle_deletable_o(idl)
   );

   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (prdy === 1'h1) break;
      end
      q = prdata;
      e = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      if (i == 20) begin
         fails++;
         end_of_test();
      end
   endtask

   // Waits for a receive clock edge, then for the bus to settle
   task automatic rxe(input logic lv);
      int i;
      logic p;
      p = rclk;
      for (i = 0; i < 60; i++) begin
         @(posedge clk);
         if (rclk === lv && p !== lv) break;
         p = rclk;
      end
      if (i == 60) begin
         fails++;
         end_of_test();
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic txs(input logic [7:0] ch, input logic kk);
      @(posedge clk);
      txc <= ch;
      txk <= kk;
      txv <= 1'h1;
      @(posedge clk);
      txv <= 1'h0;
      #1;
   endtask

   function automatic logic [9:0] ex(input logic nib, input logic r, input logic cd);
      logic [9:0] h, g;
      h = cd ? {1'h0, k_h, dat_h} : raw_h;
      g = cd ? {1'h0, k_g, dat_g} : raw_g;
      if (!nib) return r ? h : g;
      return r ? {h[9:5], g[9:5]} : {h[4:0], g[4:0]};
   endfunction

   initial begin
      {rst_n, psel, pen, pwr, crst, code, fill, loopback, tcs, ge, jact, err_g, err_h} = '0;
      {txk, txv, mode, addr, txc, enc, paddr, pwdata, busy, pat} = '0;
      {en, run, k_g, k_h, dat_g, dat_h} = {4'hf, 8'h3c, 8'h81};
      raw_h = 10'h2a5;
      raw_g = 10'h05a;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      apb(1'h0, OSR_CFG_IDX, 32'h0);
      chk(q, OSR_REG_RESET);
      apb(1'h1, OSR_CFG_IDX, 32'h8080);
      apb(1'h0, OSR_CFG_IDX, 32'h0);
      chk(q, 32'h8080);
      chk({code_o, tcs_o}, 2'h3);
      apb(1'h0, 10'h0ff, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'h1, OSR_CFG_IDX, 32'h0);
      tcs <= 1'h1;
      jact <= 1'h1;
      repeat (4) @(posedge clk);
      chk({code_o, tcs_o, bus_oe, ser_oe, tdo_oe}, 5'hf);
      en <= 1'h0;
      tcs <= 1'h0;
      repeat (4) @(posedge clk);
      chk({tcs_o, bus_oe, ser_oe, tdo_oe}, 4'h0);
      en <= 1'h1;
      jact <= 1'h0;
      repeat (4) @(posedge clk);
      chk(tdo_oe, 1'h0);
      for (m = 0; m < 2; m++) begin
         for (c = 0; c < 2; c++) begin
            mode <= m[0] ? OSR_MODE_NIB : OSR_MODE_MUX;
            code <= c[0];
            repeat (4) @(posedge clk);
            rxe(1'h1);
            chk(bus, ex(m[0], 1'h1, c[0]));
            rxe(1'h0);
            chk(bus, ex(m[0], 1'h0, c[0]));
         end
      end
      for (m = 1; m < 4; m += 2) begin
         mode <= m[1:0];
         repeat (4) @(posedge clk);
         rxe(1'h1);
         chk(bus, 10'h0);
      end
      {mode, code, err_h} <= 4'h1;
      apb(1'h1, OSR_CFG_IDX, 32'h4080);
      rxe(1'h1);
      chk(bus, 10'h3ff);
      apb(1'h1, OSR_CFG_IDX, 32'h4000);
      rxe(1'h1);
      chk(bus, raw_h);
      {addr, loopback, crst, enc} <= {5'h15, 2'h3, 10'h2e3};
      repeat (6) @(posedge clk);
      chk({rcen, strap}, 6'h35);
      addr <= 5'h0a;
      crst <= 1'h0;
      rxe(1'h1);
      chk({strap, ser_oe, dec_g}, {5'h15, 1'h0, 10'h2e3});
      {loopback, crst} <= 2'h1;
      repeat (6) @(posedge clk);
      crst <= 1'h0;
      rxe(1'h1);
      chk({strap, ser_oe, dec_g}, {5'h0a, 1'h1, 10'h0});
      ge <= 1'h1;
      txs(OSR_K28_5, 1'h1);
      txs(OSR_D16_2, 1'h0);
      chk({txv_o, txc_o}, {1'h1, OSR_D5_6});
      ge <= 1'h0;
      apb(1'h1, OSR_GE_IDX, 32'h8000);
      txs(OSR_K28_5, 1'h1);
      txs(OSR_K28_5, 1'h1);
      txs(OSR_D16_2, 1'h0);
      chk(txc_o, OSR_D16_2);
      txs(OSR_D10_1, 1'h0);
      txs(OSR_K28_5, 1'h1);
      txs(OSR_D16_2, 1'h0);
      chk(txc_o, OSR_D5_6);
      apb(1'h1, OSR_GE_IDX, 32'h0);
      txs(OSR_K28_5, 1'h1);
      txs(OSR_D16_2, 1'h0);
      chk(txc_o, OSR_D16_2);
      // Received idle pairs on channel H: busy exception, then gigabit idles
      {code, err_h} <= 2'h2;
      for (m = 0; m < 4; m++) begin
         {busy, ge, k_h, dat_h} <= {m != 0, m[1], 1'h1, OSR_K28_5};
         rxe(1'h1);
         {k_h, dat_h} <= {1'h0, m == 2 ? OSR_D16_2 : OSR_D10_1};
         rxe(1'h1);
         chk(idl, !m[0]);
      end
      // Serial inputs stay zero, so every pattern word counts as a mismatch
      pat <= 1'h1;
      rxe(1'h1);
      rxe(1'h1);
      pat <= 1'h0;
      apb(1'h0, OSR_STAT_IDX, 32'h0);
      chk(q[31:16], 16'h2);
      chk(q[3:0], 4'ha);
      end_of_test();
   end
endmodule

`default_nettype wire
